// File: verilog/utx_regs.svh
// register offsets, field positions and timing counts for the serial transmitter
// =====================================================================
// Notes on behaviour
// - mode select low means standard mode with individual pins and strobes.
// - master clear zeroes control and holding state, sets both empty statuses high; serial output goes high.
// - after master clear drops, bit timing is the transmit clock divided by sixteen.
// - control pins are latched into the control register while the latch strobe is high.
// - five to eight data bits per character, least significant bit first.
// - optional parity bit follows the most significant data bit, odd or even.
// - one low start bit, then one, one and a half or two high stop bits.
// - every serial bit cell lasts sixteen transmit clock periods.
// - holding register starts empty, shown by holding-empty status high.
// - holding register captures the transmit bus on the rising end of that pulse.
// - loading the holding register drives holding-empty status low.
// - empty shift register loads from holding on a falling clock edge, start bit first.
// - that transfer needs at least half a clock period after the load pulse ends.
// - start bit leaves half a period after the transfer, then data, parity, stops.
// - holding-empty status returns high half a clock period after the transfer.
// - a character queued during transmission follows the last stop bit with no gap.
// - when everything is sent, holding-empty and shift-empty are both high.
// - status float input high puts the status outputs in high impedance.
`ifndef UTX_REGS_SVH
`define UTX_REGS_SVH
`define UTX_OFS_CTRL 8'h00
`define UTX_OFS_TXDATA 8'h04
`define UTX_OFS_STATUS 8'h08
`define UTX_CTRL_SEL_BIT 8
`define UTX_RESP_OKAY 2'h0
`define UTX_RESP_SLVERR 2'h2
`define UTX_PIN_INIT 19'h00800
`define UTX_MIN_LEN 4'h5
`define UTX_CELL_EDGES 9'h020
`define UTX_STOP1_EDGES 9'h020
`define UTX_STOP15_EDGES 9'h030
`define UTX_STOP2_EDGES 9'h040
`endif

// File: verilog/utx_pkg.sv
// types shared by the serial transmitter files
package utx_pkg;
  typedef enum logic [1:0] {
    UTX_IDLE = 2'b00,
    UTX_PEND = 2'b01,
    UTX_RUN = 2'b10
  } utx_shift_state_t;
  typedef logic [4:0] utx_word_t;
endpackage

// File: verilog/utx_reg_if.sv
// register-side signals between the bus slave and the transmitter core
`timescale 1ns/1ps
interface utx_reg_if;
  utx_pkg::utx_word_t sw_word;
  logic sw_sel;
  logic ctrl_wr;
  logic data_wr;
  logic [7:0] data;
  logic [31:0] status;
  modport slave (output sw_word, sw_sel, ctrl_wr, data_wr, data, input status);
  modport core (input sw_word, sw_sel, ctrl_wr, data_wr, data, output status);
endinterface

// File: verilog/utx_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`include "utx_regs.svh"
module utx_sync #(
  parameter int W = 19,
  parameter logic [18:0] INIT = `UTX_PIN_INIT
) (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset
  input wire logic [W-1:0] d, // raw pins
  output logic [W-1:0] q // synchronised pins
);
  logic [W-1:0] meta_r;

  // =====================================================================
  // first stage feeds only the second
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= INIT[W-1:0];
      q <= INIT[W-1:0];
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// File: verilog/utx_axil.sv
// axi4-lite register slave for the serial transmitter
`timescale 1ns/1ps
`include "utx_regs.svh"
module utx_axil (
  input wire logic ref_clk, // system clock
  input wire logic rst, // async reset
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  utx_reg_if.slave regs // core side
);
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // =====================================================================
  // handshakes; address and data are held until both are in
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire do_wr = aw_held_r & w_held_r & ~s_axi_bvalid;
  wire aw_held_nxt = (aw_held_r & ~do_wr) | aw_take;
  wire w_held_nxt = (w_held_r & ~do_wr) | w_take;
  wire bvalid_nxt = (s_axi_bvalid & ~s_axi_bready) | do_wr;
  wire rvalid_nxt = (s_axi_rvalid & ~s_axi_rready) | ar_take;

  // address decode; status is read-only, a write to it is dropped quietly
  wire wr_ctrl = aw_addr_r == `UTX_OFS_CTRL;
  wire wr_data = aw_addr_r == `UTX_OFS_TXDATA;
  wire wr_hit = wr_ctrl | wr_data | (aw_addr_r == `UTX_OFS_STATUS);
  wire rd_ctrl = s_axi_araddr == `UTX_OFS_CTRL;
  wire rd_stat = s_axi_araddr == `UTX_OFS_STATUS;
  wire rd_hit = rd_ctrl | rd_stat | (s_axi_araddr == `UTX_OFS_TXDATA);
  wire [31:0] ctrl_word = {23'h0, regs.sw_sel, 3'h0, regs.sw_word};
  wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? regs.status : 32'h0);
  wire ctrl_hit = do_wr & wr_ctrl;
  wire data_hit = do_wr & wr_data & w_strb_r[0];

  // =====================================================================
  // channel state and register storage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UTX_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `UTX_RESP_OKAY;
      regs.ctrl_wr <= 1'b0;
      regs.data_wr <= 1'b0;
      regs.sw_word <= 5'h00;
      regs.sw_sel <= 1'b0;
      regs.data <= 8'h00;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_held_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (aw_take) aw_addr_r <= s_axi_awaddr;
      if (w_take) w_data_r <= s_axi_wdata;
      if (w_take) w_strb_r <= s_axi_wstrb;
      if (do_wr) s_axi_bresp <= wr_hit ? `UTX_RESP_OKAY : `UTX_RESP_SLVERR;
      if (ar_take) s_axi_rdata <= rd_word;
      if (ar_take) s_axi_rresp <= rd_hit ? `UTX_RESP_OKAY : `UTX_RESP_SLVERR;
      regs.ctrl_wr <= ctrl_hit & w_strb_r[0];
      regs.data_wr <= data_hit;
      if (ctrl_hit & w_strb_r[0]) regs.sw_word <= w_data_r[4:0];
      if (ctrl_hit & w_strb_r[1]) regs.sw_sel <= w_data_r[`UTX_CTRL_SEL_BIT];
      if (data_hit) regs.data <= w_data_r[7:0];
    end
  end
endmodule

// File: verilog/utx_top.sv
// standard-mode character transmitter with control latch and axi4-lite access
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "utx_regs.svh"
module utx_top (
  input wire logic ref_clk, // system clock, 125 MHz
  input wire logic rst, // async reset, active high
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic mode_sel, // low selects standard mode
  input wire logic master_clear, // high clears the block
  input wire logic tx_clk, // 16x bit-rate clock pin
  input wire logic [7:0] tx_bus, // character from host
  input wire logic tx_hold_load_n, // holding load, active low
  input wire logic parity_suppress, // high drops parity
  input wire logic parity_even_select, // high even, low odd
  input wire logic stop_length_select, // longer stop
  input wire logic char_len_sel_lo, // length select low bit
  input wire logic char_len_sel_hi, // length select high bit
  input wire logic ctrl_latch_strobe, // control latch, active high
  input wire logic status_float, // high floats status pins
  output logic serial_out, // serial line
  output logic tx_hold_empty, // holding register empty
  output logic tx_hold_empty_oe, // drive enable for it
  output logic tx_shift_empty, // shift register empty
  output logic tx_shift_empty_oe // drive enable for it
);
  utx_reg_if regs ();
  logic [18:0] pin_s;
  logic tclk_d_r;
  logic load_d_r;
  utx_pkg::utx_word_t ctrl_r;
  logic [7:0] hold_r;
  logic hold_full_r;
  logic armed_r;
  logic [10:0] shreg_r;
  logic [8:0] rem_r;
  logic [3:0] phase_r;
  utx_pkg::utx_shift_state_t st_r;
  utx_pkg::utx_shift_state_t st_nxt;
  logic [10:0] frame;

  // =====================================================================
  // bus slave and pin synchronisers
  utx_axil u_axil (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .regs(regs.slave)
  );

  // load_n idles high, so its stages reset high to avoid a false trailing edge
  utx_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .d({status_float, ctrl_latch_strobe, char_len_sel_hi, char_len_sel_lo,
        stop_length_select, parity_even_select, parity_suppress,
        tx_hold_load_n, tx_bus, tx_clk, master_clear, mode_sel}),
    .q(pin_s)
  );

  // =====================================================================
  // pin decode and edge detection
  wire mode_s = pin_s[0];
  wire clr = pin_s[1];
  wire tclk_s = pin_s[2];
  wire [7:0] bus_s = pin_s[10:3];
  wire load_n_s = pin_s[11];
  wire [4:0] word_s = pin_s[16:12];
  wire strobe_s = pin_s[17];
  wire float_s = pin_s[18];
  wire clk_rise = tclk_s & ~tclk_d_r;
  wire clk_fall = ~tclk_s & tclk_d_r;
  wire load_trail = load_n_s & ~load_d_r;
  wire std_mode = ~mode_s;

  // software can stand in for the pins; a data write acts like a load pulse
  wire hold_load = std_mode & ~clr & (load_trail | regs.data_wr);
  wire [7:0] hold_src = regs.data_wr ? regs.data : bus_s;
  wire [4:0] word_src = regs.sw_sel ? regs.sw_word : word_s;
  wire ctrl_load = strobe_s | regs.ctrl_wr;

  // =====================================================================
  // character format from the latched control word
  // length code
  wire [3:0] len = `UTX_MIN_LEN + {2'h0, ctrl_r[4:3]};
  wire [7:0] dmask = 8'hFF >> (4'h8 - len);
  wire [7:0] dm = hold_r & dmask;
  wire par_en = ~ctrl_r[0];
  wire par_bit = par_en ? (^dm ^ ~ctrl_r[1]) : 1'b1;
  // stop length; 1.5 only with five-bit characters
  wire stop_half = ctrl_r[2] & (ctrl_r[4:3] == 2'h0);
  wire [8:0] stop_edges = stop_half ? `UTX_STOP15_EDGES :
    (ctrl_r[2] ? `UTX_STOP2_EDGES : `UTX_STOP1_EDGES);
  wire [3:0] cells = 4'h1 + len + {3'h0, par_en};
  wire [8:0] rem_load = {cells, 5'h00} + stop_edges;

  // lsb first after a low start bit; parity right after the msb
  for (genvar i = 0; i < 11; i++) begin : g_frame
    if (i == 0) begin : g_start
      assign frame[i] = 1'b0;
    end else if (i <= 8) begin : g_data
      assign frame[i] = (4'(i) <= len) ? hold_r[i-1] :
        ((4'(i) == len + 4'h1) ? par_bit : 1'b1);
    end else begin : g_tail
      assign frame[i] = (4'(i) == len + 4'h1) ? par_bit : 1'b1;
    end
  end

  // =====================================================================
  // transfer timing; rem counts both clock edges so the end lands on a fall
  wire frame_end = (st_r == utx_pkg::UTX_RUN) & clk_fall & (rem_r == 9'h001);
  wire shift_free = (st_r == utx_pkg::UTX_IDLE) | frame_end;
  // falling edge into a free shift register; armed by a later rise
  wire transfer = clk_fall & hold_full_r & armed_r & shift_free & std_mode & ~clr;
  // start bit half a period after transfer
  wire start_bit = (st_r == utx_pkg::UTX_PEND) & clk_rise;
  wire next_bit = (st_r == utx_pkg::UTX_RUN) & clk_rise & (phase_r == 4'hF);
  wire busy_edge = (st_r != utx_pkg::UTX_IDLE) & (clk_rise | clk_fall);
  wire [8:0] rem_nxt = transfer ? rem_load :
    ((busy_edge & (rem_r != 9'h000)) ? rem_r - 9'h001 : rem_r);
  // load empties nothing; start bit frees the holding register
  wire hold_full_nxt = clr ? 1'b0 : (hold_load ? 1'b1 : (start_bit ? 1'b0 : hold_full_r));

  // shift state sequencing
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      utx_pkg::UTX_IDLE: if (transfer) st_nxt = utx_pkg::UTX_PEND;
      utx_pkg::UTX_PEND: if (clk_rise) st_nxt = utx_pkg::UTX_RUN;
      // queued character follows with no idle gap
      utx_pkg::UTX_RUN: if (frame_end) st_nxt = transfer ? utx_pkg::UTX_PEND : utx_pkg::UTX_IDLE;
      default: st_nxt = utx_pkg::UTX_IDLE;
    endcase
    if (clr) st_nxt = utx_pkg::UTX_IDLE;
  end

  assign regs.status = {19'h0, ctrl_r, 5'h00, std_mode, tx_shift_empty, tx_hold_empty};

  // =====================================================================
  // control, holding and counter registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tclk_d_r <= 1'b0;
      load_d_r <= 1'b1;
      ctrl_r <= 5'h00;
      hold_r <= 8'h00;
      hold_full_r <= 1'b0;
      armed_r <= 1'b0;
      st_r <= utx_pkg::UTX_IDLE;
      rem_r <= 9'h000;
    end else begin
      tclk_d_r <= tclk_s;
      load_d_r <= load_n_s;
      ctrl_r <= clr ? 5'h00 : (ctrl_load ? word_src : ctrl_r);
      hold_r <= clr ? 8'h00 : (hold_load ? hold_src : hold_r);
      hold_full_r <= hold_full_nxt;
      // a rise after the load lets the next fall transfer
      armed_r <= hold_load ? 1'b0 : (clk_rise ? 1'b1 : armed_r);
      st_r <= st_nxt;
      rem_r <= clr ? 9'h000 : rem_nxt;
    end
  end

  // serial shifter; idle line and cleared line are high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_out <= 1'b1;
      shreg_r <= 11'h7FF;
      phase_r <= 4'h0;
    end else if (clr) begin
      serial_out <= 1'b1;
      shreg_r <= 11'h7FF;
      phase_r <= 4'h0;
    end else begin
      if (transfer) shreg_r <= frame;
      else if (start_bit | next_bit) shreg_r <= {1'b1, shreg_r[10:1]};
      if (start_bit | next_bit) serial_out <= shreg_r[0];
      if (start_bit) phase_r <= 4'h0;
      else if ((st_r == utx_pkg::UTX_RUN) & clk_rise) phase_r <= phase_r + 4'h1;
    end
  end

  // status pins; holding empty high from reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_hold_empty <= 1'b1;
      tx_shift_empty <= 1'b1;
      tx_hold_empty_oe <= 1'b0;
      tx_shift_empty_oe <= 1'b0;
    end else begin
      tx_hold_empty <= ~hold_full_nxt;
      tx_shift_empty <= (st_nxt == utx_pkg::UTX_IDLE);
      tx_hold_empty_oe <= ~float_s;
      tx_shift_empty_oe <= ~float_s;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_start_edge;
    (st_r == utx_pkg::UTX_PEND) && clk_rise;
  endsequence

  sequence s_transfer_edge;
    transfer;
  endsequence

  a_clear_line: assert property (clr |=> serial_out && ctrl_r == 5'h00 && tx_hold_empty)
    else $error("master clear did not idle the transmitter");

  a_mode_gate: assert property (mode_s |-> !transfer && !hold_load)
    else $error("transfer outside standard mode");

  a_ctrl_latch: assert property (strobe_s && !regs.sw_sel && !clr |=> ctrl_r == $past(word_s))
    else $error("control word not latched from pins");

  a_hold_capture: assert property (load_trail && std_mode && !regs.data_wr && !clr
    |=> hold_r == $past(bus_s) && hold_full_r)
    else $error("holding register missed the bus");

  a_hold_busy: assert property (hold_load |=> !tx_hold_empty)
    else $error("holding empty stayed high after load");

  a_hold_idle: assert property (!hold_full_r |-> tx_hold_empty)
    else $error("holding empty low with nothing held");

  a_shift_busy: assert property (s_transfer_edge |=> !tx_shift_empty)
    else $error("shift empty high after transfer");

  a_xfer_edge: assert property ($rose(st_r == utx_pkg::UTX_PEND) |-> $past(clk_fall) && $past(armed_r))
    else $error("transfer not on an armed falling edge");

  a_start_wait: assert property (s_transfer_edge |=> st_r == utx_pkg::UTX_PEND && serial_out)
    else $error("start bit began with the transfer");

  a_start_bit: assert property (s_start_edge ##0 (!clr && !hold_load)
    |=> (!serial_out && tx_hold_empty) ##1 (!serial_out || $past(clr)))
    else $error("start bit or holding empty late");

  a_cell_hold: assert property ((st_r == utx_pkg::UTX_RUN) && clk_rise && phase_r != 4'hF && !clr
    |=> $stable(serial_out))
    else $error("serial output changed inside a cell");

  a_no_gap: assert property (frame_end && hold_full_r && armed_r && std_mode && !clr
    |=> st_r == utx_pkg::UTX_PEND)
    else $error("queued character did not follow at once");

  a_all_sent: assert property (st_r == utx_pkg::UTX_IDLE && !hold_full_r
    |-> serial_out && tx_hold_empty && tx_shift_empty)
    else $error("idle without both empties high");

  a_float_oe: assert property (float_s |=> !tx_hold_empty_oe && !tx_shift_empty_oe)
    else $error("status pins driven while floated");
endmodule

// File: tb/utx_rx_model.sv
// remote serial receiver model that samples the line in mid-cell
`timescale 1ns/1ps
module utx_rx_model (
  input wire logic tx_clk, // 16x bit clock
  input wire logic serial_out, // line from the transmitter
  input wire logic [3:0] nbits, // cells after start: data, parity, stops
  output logic [10:0] frame, // captured cells, first one in bit 0
  output logic next_cell, // cell right after the last stop
  output int cnt // frames seen
);
  int i;
  // ==========================================
  // frame capture
  // a low next cell is a queued start bit, so stay aligned instead of resyncing
  initial begin
    frame = 11'h000;
    next_cell = 1'h1;
    cnt = 0;
  end
  always begin
    @(negedge serial_out);
    repeat (8) @(posedge tx_clk);
    do begin
      for (i = 0; i < nbits; i++) begin
        repeat (16) @(posedge tx_clk);
        frame[i] = serial_out;
      end
      repeat (16) @(posedge tx_clk);
      next_cell = serial_out;
      cnt++;
    end while (next_cell === 1'h0);
  end
endmodule

// File: tb/testbench.sv
// self-checking bench for the standard-mode character transmitter
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'h0, rst = 1'h1, tx_clk = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, tx_bus = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF, nbits = 4'hA;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, next_cell;
  logic mode_sel = 1'h0, master_clear = 1'h0, tx_hold_load_n = 1'h1, parity_suppress = 1'h0;
  logic parity_even_select = 1'h0, stop_length_select = 1'h0, char_len_sel_lo = 1'h0, char_len_sel_hi = 1'h0;
  logic ctrl_latch_strobe = 1'h1, status_float = 1'h0;
  logic serial_out, tx_hold_empty, tx_hold_empty_oe, tx_shift_empty, tx_shift_empty_oe;
  logic [10:0] frame;
  int error_cnt = 0, checked = 0, cnt, k, base;
  // ==========================================
  // clocks and instances
  // odd offset keeps tx_clk edges away from ref_clk rising edges
  always #4 ref_clk = ~ref_clk;
  initial begin
    #1;
    forever #34 tx_clk = ~tx_clk;
  end
  utx_top i_dut (.*);
  utx_rx_model i_rx (.*);
  // ==========================================
  // checking and bus tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && k < 200);
    s_axi_bready <= 1'h0;
    resp = s_axi_bresp;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && k < 200);
    s_axi_rready <= 1'h0;
    resp = s_axi_rresp;
    rd = s_axi_rdata;
    repeat (2) @(posedge ref_clk);
  endtask
  // host load pulse
  // low pulse on the holding load pin, bus set up ahead of it
  task automatic load(input logic [7:0] d);
    tx_bus <= d;
    @(posedge ref_clk);
    tx_hold_load_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    tx_hold_load_n <= 1'h1;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic wait_cnt(input int n);
    for (k = 0; k < 40000 && cnt < n; k++) @(posedge ref_clk);
    if (cnt < n) error_cnt++;
  endtask
  function automatic logic [10:0] expf(input logic [7:0] d, input logic [1:0] len, input logic ps, input logic ev);
    logic [10:0] e;
    logic [7:0] m;
    m = d & (8'hFF >> (3 - len));
    e = 11'h7FF;
    for (int i = 0; i < 5 + len; i++) e[i] = m[i];
    if (!ps) e[5 + len] = ev ? ^m : ~^m;
    return e;
  endfunction
  // two random characters, the second queued while the first is sent
  task automatic pair(input logic [1:0] len, input logic ps, input logic ev, input logic sb);
    logic [7:0] a, b;
    logic [10:0] mk;
    int nb;
    a = 8'($urandom);
    b = 8'($urandom);
    nb = 6 + len + !ps + sb;
    mk = 11'h7FF >> (11 - nb);
    nbits <= nb[3:0];
    {char_len_sel_hi, char_len_sel_lo, stop_length_select, parity_even_select, parity_suppress} <= {len, sb, ev, ps};
    base = cnt;
    load(a);
    chk("hold empty", 32'h0, tx_hold_empty);
    for (k = 0; k < 4000 && tx_hold_empty !== 1'h1; k++) @(posedge ref_clk);
    load(b);
    chk("start state", 32'h0, {tx_shift_empty, serial_out, tx_hold_empty});
    wait_cnt(base + 1);
    chk("frame", expf(a, len, ps, ev) & mk, frame & mk);
    chk("gap cell", 32'h0, next_cell);
    wait_cnt(base + 2);
    chk("frame", expf(b, len, ps, ev) & mk, frame & mk);
    repeat (20) @(posedge ref_clk);
    chk("both empty", 32'h3, {tx_hold_empty, tx_shift_empty});
  endtask
  // ==========================================
  // main sequence
  initial begin
    k = $urandom(48948);
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    repeat (6) @(posedge ref_clk);
    chk("reset levels", 32'h7, {serial_out, tx_hold_empty, tx_shift_empty});
    chk("drive enables", 32'h3, {tx_hold_empty_oe, tx_shift_empty_oe});
    status_float <= 1'h1;
    repeat (5) @(posedge ref_clk);
    chk("released", 32'h0, {tx_hold_empty_oe, tx_shift_empty_oe});
    status_float <= 1'h0;
    axr(8'h08);
    chk("status", 32'h7, rd);
    // five bits, no parity, 1.5 stops: the queued start ends a run of 104 high periods
    {char_len_sel_hi, char_len_sel_lo, stop_length_select, parity_even_select, parity_suppress} <= 5'h05;
    nbits <= 4'h6;
    base = cnt;
    load(8'h1F);
    for (k = 0; k < 4000 && tx_hold_empty !== 1'h1; k++) @(posedge ref_clk);
    load(8'h0A);
    for (k = 0; k < 400 && serial_out !== 1'h1; k++) @(posedge tx_clk);
    for (k = 0; k < 400 && serial_out !== 1'h0; k++) @(posedge tx_clk);
    chk("half stop periods", 32'h68, k);
    wait_cnt(base + 2);
    chk("half stop frame", expf(8'h0A, 2'h0, 1'h1, 1'h0) & 11'h03F, frame & 11'h03F);
    for (int c = 0; c < 16; c++) pair(c[1:0], c[2], c[3], (c[2] ^ c[3]) && c[1:0] != 2'h0);
    // software control word: eight bits, even parity, one stop
    axw(8'h00, 32'h0000011A);
    chk("ctrl resp", 32'h0, resp);
    nbits <= 4'hA;
    base = cnt;
    axw(8'h04, 32'h0000005C);
    wait_cnt(base + 1);
    chk("sw frame", expf(8'h5C, 2'h3, 1'h0, 1'h1) & 11'h3FF, frame & 11'h3FF);
    axr(8'h08);
    chk("sw status", 32'h1A07, rd);
    axr(8'h0C);
    chk("unmapped read", 32'h2, resp);
    axw(8'h0C, 32'h0000001F);
    chk("unmapped write", 32'h2, resp);
    axw(8'h00, 32'h0);
    ctrl_latch_strobe <= 1'h0;
    {char_len_sel_hi, char_len_sel_lo, stop_length_select, parity_even_select, parity_suppress} <= 5'h00;
    repeat (5) @(posedge ref_clk);
    axr(8'h08);
    chk("held control", 32'h1B07, rd);
    // clear in mid-frame
    load(8'hA5);
    repeat (300) @(posedge ref_clk);
    master_clear <= 1'h1;
    repeat (5) @(posedge ref_clk);
    chk("clear levels", 32'h7, {serial_out, tx_hold_empty, tx_shift_empty});
    master_clear <= 1'h0;
    repeat (4) @(posedge ref_clk);
    axr(8'h08);
    chk("cleared control", 32'h7, rd);
    mode_sel <= 1'h1;
    repeat (4) @(posedge ref_clk);
    load(8'h3C);
    chk("load refused", 32'h3, {tx_hold_empty, tx_shift_empty});
    axr(8'h08);
    chk("mode status", 32'h3, rd);
    final_report;
  end
  // watchdog well beyond the expected run length
  initial begin
    #760000;
    error_cnt++;
    final_report;
  end
endmodule
